//--- rtl/fpc_params.svh
// Constants for the field pair changeover block: offsets, fields, resets, timing.
// Assumes inclusion from the package and the testbench by its bare name.
//
// Functional notes
// - Protective and warning field switch together.
// - Fixed mode: first pairs, inputs ignored.
// - Fixed-moment mode selects among ten pairs.
// - After changeover time, take stable valid selection.
// - Input changes during changeover time ignored.
// - All five selection inputs evaluated.
// - Overlapped mode selects among five pairs.
// - Overlapped mode monitors both pairs during changeover.
// - Order monitoring accepts only permitted transitions.
// - New configuration applies only after complete transfer.
// - Configuration writes need engineering access.
// - Successful transfer enters safety operation immediately; the code first returns to idle with outputs off until a pair is held.
// - Store configuration in connection and scanner units.
// - Unconfigured connection unit restored from scanner copy.
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH

// Register byte offsets
`define FPC_OFF_CTRL 12'h000
`define FPC_OFF_STATUS 12'h004
`define FPC_OFF_AUTH 12'h008
`define FPC_OFF_STAGE 12'h00C
`define FPC_OFF_ORDER 12'h010
`define FPC_OFF_COMMIT 12'h014
`define FPC_OFF_ACTIVE 12'h018
`define FPC_OFF_EVENTS 12'h01C
`define FPC_OFF_MASK 12'h020

// Staged configuration word fields
`define FPC_CFG_MODE_LSB 0
`define FPC_CFG_ORDER_EN 2
`define FPC_CFG_TIME_LSB 8

// Control bits
`define FPC_CTRL_ENABLE 0

// Event bits
`define FPC_EV_CHANGE 0
`define FPC_EV_ORDER 1
`define FPC_EV_INVALID 2
`define FPC_EV_REJECT 3
`define FPC_EV_COMMIT 4
`define FPC_EV_RESTORE 5

// Reset values
`define FPC_CFG_RESET 32'h0000_0000
`define FPC_ORDER_RESET 32'hFFFF_FFFF
`define FPC_AUTH_KEY 32'h5AFE_0001

// Timing: changeover time unit is 1 us at 250 MHz
`define FPC_CLK_MHZ 250
`define FPC_TIME_UNIT_US 1
`define FPC_UNIT_CYCLES (`FPC_CLK_MHZ * `FPC_TIME_UNIT_US)

`endif

//--- rtl/fpc_pkg.sv
// Types for the field pair changeover block.
// Assumes fpc_params.svh is reachable on the include path.
package fpc_pkg;
  `include "fpc_params.svh"

  typedef enum logic [1:0] {
    FPC_MODE_FIXED,
    FPC_MODE_MOMENT,
    FPC_MODE_OVERLAP,
    FPC_MODE_RSVD
  } fpc_mode_t;

  typedef enum logic [1:0] {
    FPC_ST_IDLE,
    FPC_ST_RUN,
    FPC_ST_CHANGE,
    FPC_ST_FAULT
  } fpc_state_t;
endpackage : fpc_pkg

//--- rtl/fpc_sync_if.sv
// Interface carrying synchronised selection inputs to the top module.
// Assumes one clock domain, pclk.
`timescale 1ns/10ps
interface fpc_sync_if;
  logic [4:0] sel;
  logic stable;
  modport src (output sel, output stable);
  modport dst (input sel, input stable);
endinterface : fpc_sync_if

//--- rtl/fpc_input_sync.sv
// Three-flop synchroniser for the five pair selection inputs.
// Assumes the inputs are asynchronous to pclk.
`timescale 1ns/10ps
module fpc_input_sync
  import fpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] pair_select_inputs,
  fpc_sync_if.src sync
);
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] held;
    logic stable;
  } fpc_sync_state_t;

  fpc_sync_state_t st_reg;
  fpc_sync_state_t st_next;

  // A change counts once the second and third stages agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pair_select_inputs;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.stable = (st_reg.s2 == st_reg.s3);
    if (st_reg.s2 == st_reg.s3) begin
      st_next.held = st_reg.s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync.sel = st_reg.held;
  assign sync.stable = st_reg.stable;
endmodule : fpc_input_sync

//--- rtl/fpc_changeover.sv
// Field pair changeover controller with APB register access.
// Assumes pair_select_inputs come from an asynchronous controller and that
// the two nonvolatile images are held by the surrounding logic via ports.
`timescale 1ns/10ps
module fpc_changeover
  import fpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] pair_select_inputs,
  input wire logic enable_ok,
  input wire logic conn_configured,
  input wire logic [31:0] scanner_image,
  input wire logic [31:0] scanner_order_image,
  output logic [31:0] conn_image,
  output logic [31:0] conn_order_image,
  output logic conn_write,
  output logic [31:0] scanner_copy,
  output logic scanner_write,
  output logic [3:0] active_pair,
  output logic [3:0] incoming_pair,
  output logic overlap_active,
  output logic protect_field_en,
  output logic warn_field_en,
  output logic safety_outputs_on,
  output logic irq
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    fpc_state_t state;
    logic [31:0] cfg;
    logic [31:0] order;
    logic [31:0] stage;
    logic [31:0] stage_order;
    logic authed;
    logic restored;
    logic [15:0] ctime;
    logic [7:0] unit;
    logic [3:0] cur;
    logic [3:0] nxt;
    logic [5:0] events;
    logic [5:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] conn_image;
    logic [31:0] conn_order;
    logic conn_write;
    logic scanner_write;
    logic overlap;
    logic outs_on;
    logic irq;
  } fpc_top_state_t;

  fpc_top_state_t st_reg;
  fpc_top_state_t st_next;
  // Selection pins reach the engine only through the synchroniser
  fpc_sync_if sync_bus ();

  fpc_input_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pair_select_inputs(pair_select_inputs),
    .sync(sync_bus.src)
  );

  // ************************************************************
  // Functions
  // ************************************************************

  // Decode selection code to a pair index; 4'hF means invalid
  function automatic logic [3:0] fpc_decode(input fpc_mode_t mode, input logic [4:0] sel);
    logic [3:0] idx;
    idx = 4'hF;
    if (mode == FPC_MODE_OVERLAP) begin
      // One-hot: up to five pairs
      case (sel)
        5'h01: idx = 4'h0;
        5'h02: idx = 4'h1;
        5'h04: idx = 4'h2;
        5'h08: idx = 4'h3;
        5'h10: idx = 4'h4;
        default: idx = 4'hF;
      endcase
    end else begin
      // Two-of-five: ten pairs, each code exactly two inputs high
      case (sel)
        5'h03: idx = 4'h0;
        5'h05: idx = 4'h1;
        5'h09: idx = 4'h2;
        5'h11: idx = 4'h3;
        5'h06: idx = 4'h4;
        5'h0A: idx = 4'h5;
        5'h12: idx = 4'h6;
        5'h0C: idx = 4'h7;
        5'h14: idx = 4'h8;
        5'h18: idx = 4'h9;
        default: idx = 4'hF;
      endcase
    end
    return idx;
  endfunction : fpc_decode

  // Permission bit for a transition: order word holds a 3-bit successor
  // offset mask per source pair, bit = (to - from) mod 10 in 1..3, plus stay
  function automatic logic fpc_allowed(input logic [31:0] ord, input logic [3:0] from,
                                       input logic [3:0] to);
    logic [4:0] diff;
    diff = (to >= from) ? 5'(to - from) : 5'(5'd10 + 5'(to) - 5'(from));
    if (diff == 5'd0) begin
      return 1'b1;
    end
    if (diff > 5'd3 || from > 4'd9) begin
      return 1'b0;
    end
    return ord[5'(from) * 5'd3 + diff - 5'd1];
  endfunction : fpc_allowed

  // Fields of the live configuration and the bus decode
  fpc_mode_t mode;
  logic order_en;
  logic [15:0] ctime_cfg;
  logic [3:0] want;
  logic apb_wr;
  logic apb_rd;
  logic ev_clear; // Events register read this cycle
  assign mode = fpc_mode_t'(st_reg.cfg[`FPC_CFG_MODE_LSB +: 2]);
  assign order_en = st_reg.cfg[`FPC_CFG_ORDER_EN];
  assign ctime_cfg = st_reg.cfg[`FPC_CFG_TIME_LSB +: 16];
  assign want = fpc_decode(mode, sync_bus.sel);
  // Taken once per access: the answer flop masks the standing request
  assign apb_wr = psel && penable && pwrite && !st_reg.pready;
  assign apb_rd = psel && penable && !pwrite && !st_reg.pready;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    // Events raised this cycle are gathered apart, so a read-clear cannot eat them
    st_next.events = 6'h00;
    ev_clear = 1'b0;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    st_next.conn_write = 1'b0;
    st_next.scanner_write = 1'b0;

    // Unconfigured connection unit takes the scanner copy once
    if (!st_reg.restored) begin
      st_next.restored = 1'b1;
      if (!conn_configured) begin
        st_next.cfg = scanner_image;
        st_next.order = scanner_order_image;
        st_next.conn_image = scanner_image;
        st_next.conn_order = scanner_order_image;
        st_next.conn_write = 1'b1;
        st_next.events[`FPC_EV_RESTORE] = 1'b1;
      end
    end

    // Changeover engine; outputs stay off until a valid pair is held
    case (st_reg.state)
      FPC_ST_IDLE: begin
        st_next.outs_on = 1'b0;
        st_next.overlap = 1'b0;
        if (mode == FPC_MODE_FIXED) begin
          st_next.cur = 4'h0;
          st_next.state = FPC_ST_RUN;
        end else if (sync_bus.stable && want != 4'hF) begin
          st_next.cur = want;
          st_next.state = FPC_ST_RUN;
        end
      end
      FPC_ST_RUN: begin
        st_next.outs_on = enable_ok;
        st_next.overlap = 1'b0;
        if (mode == FPC_MODE_FIXED) begin
          st_next.cur = 4'h0;
        end else if (sync_bus.stable && want == 4'hF) begin
          st_next.state = FPC_ST_FAULT;
          st_next.events[`FPC_EV_INVALID] = 1'b1;
        end else if (sync_bus.stable && want != st_reg.cur) begin
          if (order_en && !fpc_allowed(st_reg.order, st_reg.cur, want)) begin
            st_next.state = FPC_ST_FAULT;
            st_next.events[`FPC_EV_ORDER] = 1'b1;
          end else begin
            st_next.nxt = want;
            st_next.ctime = ctime_cfg;
            st_next.unit = 8'(`FPC_UNIT_CYCLES - 1);
            st_next.overlap = (mode == FPC_MODE_OVERLAP);
            st_next.state = FPC_ST_CHANGE;
          end
        end
      end
      FPC_ST_CHANGE: begin
        // Inputs are not looked at while the time runs
        st_next.outs_on = enable_ok;
        if (st_reg.unit != 8'h00) begin
          st_next.unit = st_reg.unit - 8'h01;
        end else if (st_reg.ctime != 16'h0000) begin
          st_next.ctime = st_reg.ctime - 16'h0001;
          st_next.unit = 8'(`FPC_UNIT_CYCLES - 1);
        end else begin
          st_next.overlap = 1'b0;
          st_next.events[`FPC_EV_CHANGE] = 1'b1;
          if (mode == FPC_MODE_MOMENT) begin
            // Take whatever is selected stably and validly now
            if (sync_bus.stable && want != 4'hF) begin
              if (order_en && !fpc_allowed(st_reg.order, st_reg.cur, want)) begin
                st_next.state = FPC_ST_FAULT;
                st_next.events[`FPC_EV_ORDER] = 1'b1;
              end else begin
                st_next.cur = want;
                st_next.state = FPC_ST_RUN;
              end
            end else begin
              st_next.state = FPC_ST_FAULT;
              st_next.events[`FPC_EV_INVALID] = 1'b1;
            end
          end else begin
            st_next.cur = st_reg.nxt;
            st_next.state = FPC_ST_RUN;
          end
        end
      end
      FPC_ST_FAULT: begin
        // Latched until a commit or a clear through the control word
        st_next.outs_on = 1'b0;
        st_next.overlap = 1'b0;
      end
      default: st_next.state = FPC_ST_FAULT;
    endcase

    // A restored image restarts the engine, so the new mode is qualified first
    if (!st_reg.restored && !conn_configured) begin
      st_next.state = FPC_ST_IDLE;
    end

    // APB access: one wait cycle, pready from a flop
    if (apb_wr || apb_rd) begin
      st_next.pready = 1'b1;
      st_next.prdata = 32'h0000_0000;
    end
    if (apb_wr) begin
      case (paddr)
        `FPC_OFF_AUTH: st_next.authed = (pwdata == `FPC_AUTH_KEY);
        `FPC_OFF_STAGE, `FPC_OFF_ORDER, `FPC_OFF_COMMIT: begin
          if (!st_reg.authed) begin
            st_next.pslverr = 1'b1;
            st_next.events[`FPC_EV_REJECT] = 1'b1;
          end else if (paddr == `FPC_OFF_STAGE) begin
            st_next.stage = pwdata;
          end else if (paddr == `FPC_OFF_ORDER) begin
            st_next.stage_order = pwdata;
          end else begin
            // Live config untouched until the whole image is staged
            st_next.cfg = st_reg.stage;
            st_next.order = st_reg.stage_order;
            st_next.conn_image = st_reg.stage;
            st_next.conn_order = st_reg.stage_order;
            st_next.conn_write = 1'b1;
            st_next.scanner_write = 1'b1;
            st_next.state = FPC_ST_IDLE;
            st_next.events[`FPC_EV_COMMIT] = 1'b1;
          end
        end
        `FPC_OFF_MASK: st_next.mask = pwdata[5:0];
        `FPC_OFF_CTRL: begin
          // Writing the enable bit leaves a latched fault, as does a commit
          if (pwdata[`FPC_CTRL_ENABLE] && st_reg.state == FPC_ST_FAULT) begin
            st_next.state = FPC_ST_IDLE;
          end
        end
        default: st_next.pslverr = 1'b1;
      endcase
    end
    if (apb_rd) begin
      case (paddr)
        `FPC_OFF_CTRL: st_next.prdata = {30'h0, st_reg.state == FPC_ST_FAULT, 1'b0};
        `FPC_OFF_STATUS: st_next.prdata = {26'h0, st_reg.outs_on, st_reg.overlap,
                                           st_reg.authed, 1'b0, st_reg.state};
        `FPC_OFF_AUTH: st_next.prdata = {31'h0, st_reg.authed};
        `FPC_OFF_STAGE: st_next.prdata = st_reg.cfg;
        `FPC_OFF_ORDER: st_next.prdata = st_reg.order;
        `FPC_OFF_ACTIVE: st_next.prdata = {19'h0, sync_bus.sel, st_reg.nxt, st_reg.cur};
        `FPC_OFF_EVENTS: begin
          st_next.prdata = {26'h0, st_reg.events};
          // Clear on read; only bits already reported are dropped
          ev_clear = 1'b1;
        end
        `FPC_OFF_MASK: st_next.prdata = {26'h0, st_reg.mask};
        default: st_next.pslverr = 1'b1;
      endcase
    end
    // Set wins over the read-clear: raised bits are merged after the clear
    st_next.events = st_next.events | (ev_clear ? 6'h00 : st_reg.events);
    st_next.irq = |(st_next.events & st_next.mask);
  end

  // Reset leaves the engine idle with the permissive order word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.state <= FPC_ST_IDLE;
      st_reg.cfg <= `FPC_CFG_RESET;
      st_reg.order <= `FPC_ORDER_RESET;
      st_reg.stage_order <= `FPC_ORDER_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // Outputs, all from flops
  // ************************************************************
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign conn_image = st_reg.conn_image;
  assign conn_order_image = st_reg.conn_order;
  assign conn_write = st_reg.conn_write;
  assign scanner_copy = st_reg.conn_image;
  assign scanner_write = st_reg.scanner_write;
  assign active_pair = st_reg.cur;
  assign incoming_pair = st_reg.nxt;
  assign overlap_active = st_reg.overlap;
  // Both fields of a pair share one enable source
  assign protect_field_en = st_reg.outs_on;
  assign warn_field_en = st_reg.outs_on;
  assign safety_outputs_on = st_reg.outs_on;
  assign irq = st_reg.irq;
endmodule : fpc_changeover

//--- test/fpc_changeover_properties.sv
// Checker for the field pair changeover block: bus timing and output relations.
// Assumes it is bound to fpc_changeover and sees only that module's ports.
`timescale 1ns/10ps
module fpc_changeover_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic enable_ok,
  input wire logic [31:0] scanner_image,
  input wire logic [31:0] scanner_order_image,
  input wire logic [31:0] conn_image,
  input wire logic [31:0] conn_order_image,
  input wire logic conn_write,
  input wire logic [31:0] scanner_copy,
  input wire logic scanner_write,
  input wire logic [3:0] active_pair,
  input wire logic [3:0] incoming_pair,
  input wire logic overlap_active,
  input wire logic protect_field_en,
  input wire logic warn_field_en,
  input wire logic safety_outputs_on
);
  // ****************
  // Properties
  // ****************
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_fields_together:
    assert property (protect_field_en == warn_field_en && warn_field_en == safety_outputs_on)
    else $error("protective and warning enables differ");
  a_pair_range:
    assert property (active_pair <= 4'h9 && incoming_pair <= 4'h9)
    else $error("pair number out of range");
  a_overlap_span:
    assert property ($rose(overlap_active) |-> overlap_active [*8])
    else $error("overlap dropped too early");
  a_outs_need_ok:
    assert property (!enable_ok [*2] |-> !safety_outputs_on)
    else $error("outputs on without enabling conditions");
  a_commit_both:
    assert property (scanner_write |-> conn_write && conn_image == scanner_copy)
    else $error("commit did not store both copies");
  a_restore_copy:
    assert property (conn_write && !scanner_write |->
      conn_image == scanner_image && conn_order_image == scanner_order_image)
    else $error("restore image differs from scanner copy");
  a_ready_wait:
    assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_ready_pulse:
    assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_with_ready:
    assert property (pslverr |-> pready)
    else $error("error flag without ready");
endmodule : fpc_changeover_properties

bind fpc_changeover fpc_changeover_properties u_fpc_changeover_properties (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .enable_ok, .scanner_image, .scanner_order_image,
  .conn_image, .conn_order_image, .conn_write, .scanner_copy, .scanner_write, .active_pair,
  .incoming_pair, .overlap_active, .protect_field_en, .warn_field_en, .safety_outputs_on);

//--- test/fpc_ctrl_model.sv
// Machine controller model driving the five pair selection inputs.
// Assumes the bench names the wanted code and a lag of 0 to 3 cycles.
`timescale 1ns/10ps
module fpc_ctrl_model (
  input wire logic pclk,
  input wire logic [4:0] want,
  input wire logic [1:0] lag,
  output logic [4:0] pair_select_inputs
);
  initial pair_select_inputs = 5'h00;
  // Follow the wanted code late, so slow controllers are seen too; the bench only
  // asks for changeovers in the permitted sequence, except where it means a fault
  always @(posedge pclk) begin
    if (want !== pair_select_inputs) begin
      repeat (lag) @(posedge pclk);
      pair_select_inputs <= want;
    end
  end
endmodule : fpc_ctrl_model

//--- test/tb.sv
// Testbench for the field pair changeover block: APB traffic, selection codes, pins.
// Assumes the design, its package, the checker and the controller model are compiled.
`timescale 1ns/10ps
`include "fpc_params.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, enable_ok, conn_configured;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, scanner_image, scanner_order_image;
  logic pready, pslverr, conn_write, scanner_write, overlap_active, irq;
  logic protect_field_en, warn_field_en, safety_outputs_on;
  logic [31:0] conn_image, conn_order_image, scanner_copy;
  logic [3:0] active_pair, incoming_pair;
  logic [4:0] want, pair_select_inputs;
  logic [1:0] lag;
  logic [64:0] exp_q[$];
  logic [64:0] note;
  integer seed = 32'h5FBAC3FC;
  int err_count = 0;
  int checks_done = 0;
  int i;

  always #2 pclk = ~pclk;

  fpc_changeover u_fpc_changeover (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pair_select_inputs, .enable_ok, .conn_configured,
    .scanner_image, .scanner_order_image, .conn_image, .conn_order_image, .conn_write,
    .scanner_copy, .scanner_write, .active_pair, .incoming_pair, .overlap_active,
    .protect_field_en, .warn_field_en, .safety_outputs_on, .irq);
  fpc_ctrl_model u_fpc_ctrl_model (.pclk, .want, .lag, .pair_select_inputs);

  // ****************
  // Checking
  // ****************
  // Bus answers are matched against the oldest note left by the driver
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      note = exp_q.pop_front();
      cmp_bus(prdata & note[32:1], pslverr, note);
    end
  end

  task automatic cmp_bus(input logic [31:0] d, input logic e, input logic [64:0] x);
    checks_done++;
    if (d !== x[64:33] || e !== x[0]) begin
      err_count++;
      $display("mismatch at %0t: bus got %h/%b want %h/%b", $time, d, e, x[64:33], x[0]);
    end
  endtask : cmp_bus

  task automatic chk_pin(input logic [31:0] a, input logic [31:0] x, input string what);
    checks_done++;
    if (a !== x) begin
      err_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, a, x);
    end
  endtask : chk_pin

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // ****************
  // Stimulus
  // ****************
  // One APB transfer; the request stands until ready is seen, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    exp_q.push_back({d & m, m, e});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Unlock, stage a mode word and an order word, and apply them if asked
  task automatic cfg(input logic [31:0] c, input logic [31:0] o, input logic go);
    apb(1'b1, `FPC_OFF_AUTH, `FPC_AUTH_KEY, 32'h0, 1'b0);
    apb(1'b1, `FPC_OFF_ORDER, o, 32'h0, 1'b0);
    apb(1'b1, `FPC_OFF_STAGE, c, 32'h0, 1'b0);
    if (go) apb(1'b1, `FPC_OFF_COMMIT, 32'h0, 32'h0, 1'b0);
  endtask : cfg

  initial begin
    {psel, penable, pwrite, enable_ok, conn_configured} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    want = 5'h00;
    lag = 2'h0;
    scanner_image = 32'h0000_0205;
    scanner_order_image = 32'h0000_0FFF;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `FPC_OFF_EVENTS, 32'h20, 32'h20, 1'b0);
    chk_pin(conn_image, scanner_image, "restored image");
    apb(1'b1, `FPC_OFF_STAGE, 32'h2, 32'h0, 1'b1);
    apb(1'b1, 12'h0FC, 32'h0, 32'h0, 1'b1);
    apb(1'b0, `FPC_OFF_EVENTS, 32'h08, 32'h08, 1'b0);
    cfg(32'h0, 32'hFFFF_FFFF, 1'b1);
    enable_ok <= 1'b1;
    // Fixed mode must ignore whatever the controller drives
    for (i = 0; i < 6; i++) begin
      want <= 5'($random(seed));
      lag <= 2'($random(seed));
      repeat (40) @(posedge pclk);
      chk_pin(32'(active_pair), 32'h0, "fixed pair");
      chk_pin(32'(safety_outputs_on), 32'h1, "outputs");
    end
    want <= 5'h08;
    cfg(32'h2, 32'hFFFF_FFFF, 1'b0);
    repeat (300) @(posedge pclk);
    chk_pin(32'(active_pair), 32'h0, "staged only");
    want <= 5'h01;
    apb(1'b1, `FPC_OFF_COMMIT, 32'h0, 32'h0, 1'b0);
    repeat (300) @(posedge pclk);
    chk_pin(scanner_copy, 32'h2, "scanner copy");
    // Walk the one-hot pairs; both pairs are watched through the changeover
    for (i = 1; i < 5; i++) begin
      want <= 5'h01 << i;
      lag <= 2'($random(seed));
      repeat (60) @(posedge pclk);
      chk_pin(32'(overlap_active), 32'h1, "overlap");
      chk_pin(32'(incoming_pair), 32'(i), "incoming");
      chk_pin(32'(active_pair), 32'(i - 1), "outgoing");
      repeat (250) @(posedge pclk);
      chk_pin(32'(active_pair), 32'(i), "new pair");
      apb(1'b0, `FPC_OFF_EVENTS, 32'h01, 32'h01, 1'b0);
    end
    cfg(32'h6, 32'h0, 1'b1);
    apb(1'b1, `FPC_OFF_MASK, 32'h02, 32'h0, 1'b0);
    repeat (300) @(posedge pclk);
    want <= 5'h01;
    repeat (300) @(posedge pclk);
    chk_pin(32'(safety_outputs_on), 32'h0, "order fault");
    chk_pin(32'(irq), 32'h1, "irq raised");
    apb(1'b0, `FPC_OFF_EVENTS, 32'h02, 32'h02, 1'b0);
    repeat (2) @(posedge pclk);
    chk_pin(32'(irq), 32'h0, "irq cleared");
    apb(1'b1, `FPC_OFF_CTRL, 32'h1, 32'h0, 1'b0);
    want <= 5'h03;
    cfg(32'h1, 32'hFFFF_FFFF, 1'b1);
    repeat (300) @(posedge pclk);
    chk_pin(32'(safety_outputs_on), 32'h1, "after commit");
    // A move inside the changeover time is ignored; the code at expiry wins
    want <= 5'h05;
    repeat (60) @(posedge pclk);
    want <= 5'h09;
    repeat (60) @(posedge pclk);
    chk_pin(32'(active_pair), 32'h0, "held in change");
    chk_pin(32'(incoming_pair), 32'h1, "request kept");
    chk_pin(32'(overlap_active), 32'h0, "no overlap");
    repeat (200) @(posedge pclk);
    chk_pin(32'(active_pair), 32'h2, "pair at expiry");
    want <= 5'h00;
    repeat (300) @(posedge pclk);
    chk_pin(32'(safety_outputs_on), 32'h0, "invalid code");
    apb(1'b0, `FPC_OFF_EVENTS, 32'h04, 32'h04, 1'b0);
    report_and_stop();
  end

  // A hang counts as a mismatch and ends the run the normal way
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    report_and_stop();
  end
endmodule : tb
